/* verilog/rmts_top.sv */
// Reset monitor, trigger and status block with an AXI4-Lite register port
// Operation
// RL1: status pin toggles once every 2^N trigger pulses, N from 0 to 6.
// RL2: controller changes the divider exponent only after reset, before channel setup.
// RL3: trigger rise prepares channel codes; the following fall switches the outputs.
// RL4: power-up reset restores defaults; no access for 250 us afterwards.
// RL5: every channel data value is the zero code after a power-up reset.
// RL6: a digital supply loss gives the same power-up reset.
// RL7: supply monitor word reads 0xCAFE after every power-up reset.
// RL8: any write to the supply monitor word makes it 0xABBA.
// RL9: controller reads 0xCAFE as uninitialised or digital supply failure.
// RL10: analog failure clears outputs, keeps data, no reset, resumes on recovery.
// RL11: during an analog failure every channel is loaded with the zero code.
// RL12: a supply collapse counts only after 1 ms of below-threshold report.
// RL13: each read of the supply monitor word swaps 0xABBA and 0xBAAB.
// RL14: any reset clears the trigger pulse counter and idles the status pin.
`timescale 1ns/1ps
`default_nettype none
module rmts_top
    import rmts_pkg::*;
#(
    parameter int unsigned CH = CHANNEL_COUNT,
    parameter int unsigned LOCKOUT_CYCLES = POR_DELAY_CYCLES,
    parameter int unsigned QUAL_CYCLES = SUPPLY_QUAL_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic digital_supply_low_in,
    input wire logic analog_supply_low_in,
    input wire logic conversion_trigger_input_in,
    output logic status_toggle_pin_out,
    output logic channel_clear_out,
    output logic comm_ready_out,
    output logic irq_out,
    output logic [CH*CODE_W-1:0] channel_code_out
);
    localparam int unsigned LW = $clog2(LOCKOUT_CYCLES + 1);
    localparam logic [LW-1:0] LOCK_LAST = LW'(LOCKOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Supply qualification
    logic dig_fail;
    logic ana_fail;

    rmts_supply_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_dig_qual (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .supply_low_in(digital_supply_low_in),
        .fail_out(dig_fail)
    );

    rmts_supply_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_ana_qual (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .supply_low_in(analog_supply_low_in),
        .fail_out(ana_fail)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes
    logic aw_held, w_held, next_aw_held, next_w_held, next_bvalid, next_awready, next_wready;
    logic [ADDR_W-1:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic [1:0] next_bresp, next_rresp;
    logic next_rvalid, next_arready;
    logic [31:0] next_rdata, rd_mux;
    logic wr_fire, rd_fire, wr_ok, rd_ok;

    assign wr_fire = aw_held && w_held && !bvalid_out;
    assign rd_fire = arvalid_in && arready_out;
    assign wr_ok = comm_ready_out && (wr_addr == OFS_MON || wr_addr == OFS_DIV
        || wr_addr == OFS_IRQ_STAT || wr_addr == OFS_IRQ_MASK || wr_addr == OFS_CHAN
        || wr_addr == OFS_PWR);
    assign rd_ok = comm_ready_out && (araddr_in == OFS_MON || araddr_in == OFS_DIV
        || araddr_in == OFS_IRQ_STAT || araddr_in == OFS_IRQ_MASK
        || araddr_in == OFS_CHAN || araddr_in == OFS_PWR);

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid_out;
        next_bresp = bresp_out;
        if (awvalid_in && awready_out) begin
            next_aw_held = 1'b1;
            next_wr_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_w_held = 1'b1;
            next_wr_data = wdata_in;
            next_wr_strb = wstrb_in;
        end
        if (bvalid_out && bready_in) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR; // RL4
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_rvalid = rvalid_out;
        next_rdata = rdata_out;
        next_rresp = rresp_out;
        if (rvalid_out && rready_in) begin
            next_rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rdata = rd_ok ? rd_mux : 32'h0000_0000;
            next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR; // RL4
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out <= RESP_OKAY;
            awready_out <= 1'b0;
            wready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= RESP_OKAY;
            arready_out <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            bvalid_out <= next_bvalid;
            bresp_out <= next_bresp;
            awready_out <= next_awready;
            wready_out <= next_wready;
            rvalid_out <= next_rvalid;
            rdata_out <= next_rdata;
            rresp_out <= next_rresp;
            arready_out <= next_arready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core state, returned to defaults by a qualified digital supply loss
    logic [15:0] mon, next_mon, div_exp, next_div_exp;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
    logic [CHAN_IDX_W-1:0] chan_idx, next_chan_idx;
    logic [CODE_W-1:0] chan_data [CH];
    logic [CODE_W-1:0] next_chan_data [CH];
    logic [CODE_W-1:0] prep [CH];
    logic [CODE_W-1:0] next_prep [CH];
    logic [CODE_W-1:0] live [CH];
    logic [CODE_W-1:0] next_live [CH];
    logic [CH*CODE_W-1:0] next_code;
    logic phase, next_phase, trig_prev, trig_rise, trig_fall;
    logic [6:0] pulse_cnt, next_pulse_cnt, pulse_term;
    logic [2:0] div_n;
    logic next_stat_pin, next_clear, next_ready, next_irq, ana_prev;
    logic [LW-1:0] lock_cnt, next_lock_cnt;
    logic wr_mon, rd_mon, wr_chan, core_rst;

    assign core_rst = dig_fail; // RL6
    assign wr_mon = wr_fire && wr_ok && wr_addr == OFS_MON;
    assign rd_mon = rd_fire && rd_ok && araddr_in == OFS_MON;
    assign wr_chan = wr_fire && wr_ok && wr_addr == OFS_CHAN
        && 32'(wr_data[CHAN_IDX_LSB +: CHAN_IDX_W]) < CH;
    assign trig_rise = conversion_trigger_input_in && !trig_prev;
    assign trig_fall = !conversion_trigger_input_in && trig_prev;
    assign div_n = (div_exp[2:0] > DIV_MAX) ? DIV_MAX : div_exp[2:0];
    assign pulse_term = 7'((7'h01 << div_n) - 7'h01);
    assign ev[IRQ_PWR_UP] = next_ready && !comm_ready_out;
    assign ev[IRQ_AFAIL] = ana_fail && !ana_prev;
    assign ev[IRQ_AOK] = !ana_fail && ana_prev;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (araddr_in)
            OFS_MON: rd_mux = {16'h0000, mon};
            OFS_DIV: rd_mux = {16'h0000, div_exp};
            OFS_IRQ_STAT: rd_mux = 32'(irq_stat);
            OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
            OFS_CHAN: rd_mux = 32'(chan_idx) << CHAN_IDX_LSB
                | 32'(chan_data[32'(chan_idx) % CH]);
            OFS_PWR: rd_mux = 32'({phase, comm_ready_out, ana_fail});
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_mon = mon;
        next_div_exp = div_exp;
        next_irq_mask = irq_mask;
        next_chan_idx = chan_idx;
        next_irq_stat = irq_stat;
        next_chan_data = chan_data;
        next_prep = prep;
        next_live = live;
        next_phase = phase;
        next_pulse_cnt = pulse_cnt;
        next_stat_pin = status_toggle_pin_out;
        next_lock_cnt = lock_cnt;
        next_ready = comm_ready_out;
        if (rd_mon && mon == MON_WRITTEN) begin
            next_mon = MON_TOGGLED; // RL13
        end else if (rd_mon && mon == MON_TOGGLED) begin
            next_mon = MON_WRITTEN; // RL13
        end
        if (wr_mon) begin
            next_mon = MON_WRITTEN; // RL8
        end
        if (wr_fire && wr_ok && wr_addr == OFS_DIV) begin
            for (int b = 0; b < 2; b++) begin
                if (wr_strb[b]) begin
                    next_div_exp[8*b +: 8] = wr_data[8*b +: 8];
                end
            end
        end
        if (wr_fire && wr_ok && wr_addr == OFS_IRQ_MASK && wr_strb[0]) begin
            next_irq_mask = wr_data[IRQ_W-1:0];
        end
        if (wr_fire && wr_ok && wr_addr == OFS_IRQ_STAT && wr_strb[0]) begin
            next_irq_stat = irq_stat & ~wr_data[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | ev;
        if (wr_chan) begin
            next_chan_idx = wr_data[CHAN_IDX_LSB +: CHAN_IDX_W];
            next_chan_data[32'(wr_data[CHAN_IDX_LSB +: CHAN_IDX_W])] = wr_data[CODE_W-1:0];
        end
        if (trig_rise) begin
            for (int i = 0; i < CH; i++) begin
                next_prep[i] = phase ? '0 : chan_data[i]; // RL3
            end
            if (pulse_cnt >= pulse_term) begin
                next_pulse_cnt = 7'h00;
                next_stat_pin = !status_toggle_pin_out; // RL1
            end else begin
                next_pulse_cnt = pulse_cnt + 7'h01; // RL1
            end
        end
        if (trig_fall) begin
            next_live = prep; // RL3
            next_phase = !phase;
        end
        if (!comm_ready_out) begin
            if (lock_cnt == LOCK_LAST) begin
                next_ready = 1'b1; // RL4
            end else begin
                next_lock_cnt = lock_cnt + LW'(1);
            end
        end
        for (int i = 0; i < CH; i++) begin
            next_code[i*CODE_W +: CODE_W] = ana_fail ? '0 : next_live[i]; // RL11
        end
        next_clear = ana_fail; // RL10
        if (core_rst) begin
            next_mon = MON_RESET; // RL7
            next_div_exp = DIV_RESET;
            next_irq_stat = IRQ_RESET;
            next_irq_mask = IRQ_RESET;
            next_chan_idx = '0;
            next_chan_data = '{default: '0}; // RL5
            next_prep = '{default: '0};
            next_live = '{default: '0};
            next_code = '0;
            next_phase = 1'b0;
            next_pulse_cnt = 7'h00; // RL14
            next_stat_pin = 1'b0; // RL14
            next_lock_cnt = '0; // RL4
            next_ready = 1'b0;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mon <= MON_RESET;
            div_exp <= DIV_RESET;
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            chan_idx <= '0;
            chan_data <= '{default: '0};
            prep <= '{default: '0};
            live <= '{default: '0};
            channel_code_out <= '0;
            phase <= 1'b0;
            trig_prev <= 1'b0;
            pulse_cnt <= 7'h00;
            status_toggle_pin_out <= 1'b0;
            lock_cnt <= '0;
            comm_ready_out <= 1'b0;
            channel_clear_out <= 1'b0;
            ana_prev <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            mon <= next_mon;
            div_exp <= next_div_exp;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            chan_idx <= next_chan_idx;
            chan_data <= next_chan_data;
            prep <= next_prep;
            live <= next_live;
            channel_code_out <= next_code;
            phase <= next_phase;
            trig_prev <= conversion_trigger_input_in;
            pulse_cnt <= next_pulse_cnt;
            status_toggle_pin_out <= next_stat_pin;
            lock_cnt <= next_lock_cnt;
            comm_ready_out <= next_ready;
            channel_clear_out <= next_clear;
            ana_prev <= ana_fail;
            irq_out <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [31:0] low_run;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_run <= 32'h0000_0000;
        end else if (!analog_supply_low_in) begin
            low_run <= 32'h0000_0000;
        end else if (low_run != 32'hFFFF_FFFF) begin
            low_run <= low_run + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    property p_mon_write;
        wr_mon && !core_rst |=> mon == MON_WRITTEN;
    endproperty
    a_mon_write: assert property (p_mon_write) else $error("monitor write not 0xABBA"); // RL8
    property p_mon_toggle;
        rd_mon && !wr_mon && !core_rst && mon == MON_WRITTEN |=> mon == MON_TOGGLED;
    endproperty
    a_mon_toggle: assert property (p_mon_toggle) else $error("monitor did not swap"); // RL13
    property p_por_defaults;
        core_rst |=> mon == MON_RESET && chan_data[0] == '0 && !comm_ready_out;
    endproperty
    a_por_defaults: assert property (p_por_defaults) else $error("reset defaults lost"); // RL7
    property p_ready_delay;
        $rose(comm_ready_out) |-> $past(lock_cnt) == LOCK_LAST && !$past(core_rst);
    endproperty
    a_ready_delay: assert property (p_ready_delay) else $error("lockout too short"); // RL4
    property p_locked_refused;
        rd_fire && !comm_ready_out |=> rvalid_out && rresp_out == RESP_SLVERR;
    endproperty
    a_locked_refused: assert property (p_locked_refused) else $error("access in lockout"); // RL4
    property p_ana_zero;
        ana_fail |=> channel_code_out == '0 && channel_clear_out;
    endproperty
    a_ana_zero: assert property (p_ana_zero) else $error("outputs not cleared"); // RL11
    property p_ana_keep;
        ana_fail && !core_rst && !wr_chan |=> chan_data[0] == $past(chan_data[0]);
    endproperty
    a_ana_keep: assert property (p_ana_keep) else $error("data lost in clear"); // RL10
    property p_trig_fall;
        trig_fall && !core_rst ##1 !ana_fail |=> channel_code_out[CODE_W-1:0] == $past(prep[0], 2);
    endproperty
    a_trig_fall: assert property (p_trig_fall) else $error("fall did not switch"); // RL3
    property p_div_toggle;
        trig_rise && !core_rst && pulse_cnt >= pulse_term
            |=> status_toggle_pin_out != $past(status_toggle_pin_out);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divider missed"); // RL1
    property p_div_hold;
        !trig_rise && !core_rst |=> $stable(status_toggle_pin_out);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("stray status toggle"); // RL1
    property p_rst_pin;
        core_rst |=> !status_toggle_pin_out && pulse_cnt == 7'h00;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin not idled"); // RL14
    property p_qual;
        $rose(ana_fail) |-> low_run >= QUAL_CYCLES;
    endproperty
    a_qual: assert property (p_qual) else $error("collapse too early"); // RL12

    c_ready: cover property ($rose(comm_ready_out));
    c_ana_fail: cover property ($rose(ana_fail));
    c_toggle: cover property ($changed(status_toggle_pin_out));
    c_mon_swap: cover property (rd_mon ##1 mon == MON_TOGGLED);
endmodule
`default_nettype wire

/* inc/rmts_pkg.sv */
// Shared constants for the reset monitor, trigger and status block
package rmts_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned POR_DELAY_US = 250;
    localparam int unsigned POR_DELAY_CYCLES = ((CLK_HZ / 1000) * POR_DELAY_US + 999) / 1000;
    localparam int unsigned SUPPLY_QUAL_MS = 1;
    localparam int unsigned SUPPLY_QUAL_CYCLES = (CLK_HZ / 1000) * SUPPLY_QUAL_MS;
    localparam int unsigned CHANNEL_COUNT = 96;
    localparam int unsigned CODE_W = 12;
    localparam int unsigned ADDR_W = 8;

    localparam logic [7:0] OFS_MON = 8'h08;
    localparam logic [7:0] OFS_DIV = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_CHAN = 8'h18;
    localparam logic [7:0] OFS_PWR = 8'h1C;

    localparam logic [15:0] MON_RESET = 16'hCAFE;
    localparam logic [15:0] MON_WRITTEN = 16'hABBA;
    localparam logic [15:0] MON_TOGGLED = 16'hBAAB;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [2:0] DIV_MAX = 3'h6;

    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_PWR_UP = 0;
    localparam int unsigned IRQ_AFAIL = 1;
    localparam int unsigned IRQ_AOK = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    localparam int unsigned CHAN_IDX_LSB = 16;
    localparam int unsigned CHAN_IDX_W = 7;

    localparam int unsigned PWR_ANA_FAIL = 0;
    localparam int unsigned PWR_READY = 1;
    localparam int unsigned PWR_PHASE = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* verilog/rmts_supply_qual.sv */
// Supply collapse qualifier: flags a supply failure after a long low report
`timescale 1ns/1ps
`default_nettype none
module rmts_supply_qual #(
    parameter int unsigned QUAL_CYCLES = 40000
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic supply_low_in,
    output logic fail_out
);
    localparam int unsigned CW = $clog2(QUAL_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(QUAL_CYCLES - 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_fail;

    always_comb begin
        next_cnt = cnt;
        next_fail = 1'b0;
        if (!supply_low_in) begin
            next_cnt = '0;
        end else if (cnt != LAST) begin
            next_cnt = cnt + CW'(1);
        end
        if (supply_low_in && (cnt == LAST || fail_out)) begin
            next_fail = 1'b1; // RL12
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
            fail_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            fail_out <= next_fail;
        end
    end
endmodule
`default_nettype wire

/* bench/rmts_trig_src.sv */
// Trigger waveform source standing in for the external square-wave generator
`timescale 1ns/1ps
`default_nettype none
module rmts_trig_src (
    input wire logic sys_clk_in,
    input wire logic start_in,
    input wire logic [7:0] count_in,
    output logic trig_out,
    output logic busy_out
);
    logic [7:0] left = 8'h00;
    logic [1:0] ph = 2'h0;
    initial trig_out = 1'b0;
    initial busy_out = 1'b0;
    // Square pulses of four cycles high, four low; idles low between bursts
    always @(posedge sys_clk_in) begin
        if (start_in && !busy_out) begin
            left <= count_in;
            busy_out <= (count_in != 8'h00);
            ph <= 2'h0;
        end else if (busy_out) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                trig_out <= !trig_out;
                if (trig_out) begin
                    left <= left - 8'h01;
                    if (left == 8'h01) busy_out <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* bench/rmts_top_tb.sv */
// Self-checking testbench for the reset monitor, trigger and status block
`timescale 1ns/1ps
`default_nettype none
module rmts_top_tb;
    import rmts_pkg::*;
    localparam int unsigned NCH = 4;
    localparam int unsigned LOCK = 20;
    localparam int unsigned QUAL = 8;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic dlow = 1'b0, alow = 1'b0, tg_start = 1'b0;
    logic [7:0] tg_cnt = 8'h00;
    wire logic awready, wready, bvalid, arready, rvalid, trig, tg_busy, stp, clr, cready, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [NCH*CODE_W-1:0] codes;
    logic stp_q = 1'b0;
    int n_tog = 0, n_errors = 0, tests_run = 0;
    logic [31:0] d, x, t;
    logic [1:0] r;
    ////////////////////////////////////////////////////////////////////////////////
    rmts_top #(.CH(NCH), .LOCKOUT_CYCLES(LOCK), .QUAL_CYCLES(QUAL)) i_rmts_top (
        .sys_clk_in(clk), .nrst_in(nrst), .awaddr_in(awaddr), .awvalid_in(awvalid),
        .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
        .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
        .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
        .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
        .digital_supply_low_in(dlow), .analog_supply_low_in(alow),
        .conversion_trigger_input_in(trig), .status_toggle_pin_out(stp),
        .channel_clear_out(clr), .comm_ready_out(cready), .irq_out(irq),
        .channel_code_out(codes));
    rmts_trig_src i_rmts_trig_src (.sys_clk_in(clk), .start_in(tg_start), .count_in(tg_cnt),
        .trig_out(trig), .busy_out(tg_busy));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        stp_q <= stp;
        if (stp !== stp_q) n_tog <= n_tog + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        s = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        s = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] v;
        logic [1:0] s;
        axr(a, v, s);
        chk(32'(s), 32'(RESP_OKAY), m);
        chk(v, e, m);
    endtask
    task automatic pulses(input int n);
        @(posedge clk);
        tg_cnt <= 8'(n);
        tg_start <= 1'b1;
        @(posedge clk);
        tg_start <= 1'b0;
        @(posedge clk);
        while (tg_busy) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    task automatic rst();
        int n;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        axr(OFS_MON, t, r);
        chk(32'(r), 32'(RESP_SLVERR), "early access accepted");
        chk(32'(cready), 32'h0000_0000, "ready too soon");
        n = 0;
        while (!cready && n < LOCK + 4) begin
            @(posedge clk);
            n++;
        end
        chk(32'(cready), 32'h0000_0001, "lockout never ends");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0000_422f));
        rst();
        chk(32'(codes != '0), 32'h0000_0000, "codes not zero");
        chk(32'({stp, clr, irq}), 32'h0000_0000, "outputs not idle");
        rchk(OFS_MON, 32'(MON_RESET), "monitor reset value");
        rchk(OFS_MON, 32'(MON_RESET), "monitor changed on read");
        rchk(OFS_DIV, 32'h0000_0000, "divider reset value");
        rchk(OFS_IRQ_MASK, 32'h0000_0000, "mask reset value");
        axr(8'h40, t, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped read accepted");
        axw(OFS_MON, $urandom, r);
        rchk(OFS_MON, 32'(MON_WRITTEN), "monitor write value");
        rchk(OFS_MON, 32'(MON_TOGGLED), "monitor first swap");
        rchk(OFS_MON, 32'(MON_WRITTEN), "monitor second swap");
        $display("test 1 done");
        for (int n = 0; n < 8; n++) begin
            int e;
            e = 1 << ((n > 6) ? 6 : n);
            rst();
            d = $urandom;
            axw(OFS_DIV, {d[31:3], 3'(n)}, r);
            rchk(OFS_DIV, {16'h0000, d[15:3], 3'(n)}, "divider readback");
            x = 32'(n_tog);
            pulses(e - 1);
            chk(32'(n_tog) - x, 32'h0000_0000, "early toggle");
            pulses(1);
            chk(32'(n_tog) - x, 32'h0000_0001, "missed toggle");
            pulses(e);
            chk(32'(n_tog) - x, 32'h0000_0002, "second toggle");
        end
        $display("test 2 done");
        rst();
        d = $urandom;
        x = {9'h000, 5'h00, d[13:12], 4'h0, d[11:0]};
        axw(OFS_CHAN, x, r);
        rchk(OFS_CHAN, x, "channel readback");
        pulses(1);
        chk(32'(codes[CODE_W*d[13:12] +: CODE_W]), 32'(d[11:0]), "square high");
        pulses(1);
        chk(32'(codes[CODE_W*d[13:12] +: CODE_W]), 32'h0000_0000, "square low");
        pulses(1);
        $display("test 3 done");
        axw(OFS_IRQ_MASK, 32'h0000_0002, r);
        axw(OFS_MON, 32'h0000_0000, r);
        @(posedge clk);
        alow <= 1'b1;
        repeat (QUAL - 2) @(posedge clk);
        alow <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(clr), 32'h0000_0000, "short dip cleared");
        alow <= 1'b1;
        repeat (QUAL + 3) @(posedge clk);
        chk(32'(clr), 32'h0000_0001, "no clear");
        chk(32'(codes != '0), 32'h0000_0000, "codes during failure");
        chk(32'(irq), 32'h0000_0001, "no interrupt");
        rchk(OFS_CHAN, x, "data lost");
        rchk(OFS_MON, 32'(MON_WRITTEN), "analog fault reset");
        rchk(OFS_PWR, 32'h0000_0007, "power status in failure");
        axw(OFS_IRQ_STAT, 32'h0000_0002, r);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000, "interrupt not cleared");
        alow <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(clr), 32'h0000_0000, "clear stuck");
        chk(32'(codes[CODE_W*d[13:12] +: CODE_W]), 32'(d[11:0]), "code lost");
        rchk(OFS_IRQ_STAT, 32'h0000_0005, "event flags");
        $display("test 4 done");
        chk(32'(stp), 32'h0000_0001, "pin not toggled");
        @(posedge clk);
        dlow <= 1'b1;
        repeat (QUAL + 3) @(posedge clk);
        chk(32'({cready, stp}), 32'h0000_0000, "no supply reset");
        dlow <= 1'b0;
        while (!cready) @(posedge clk);
        rchk(OFS_MON, 32'(MON_RESET), "monitor not restored");
        chk(32'(codes != '0), 32'h0000_0000, "codes after supply loss");
        $display("test 5 done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
